// *** hdl/imd_decode_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module imd_decode_top (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  output logic memReq,
  output logic memWrite,
  output logic memProgSpace,
  output logic [31:0] memAddr,
  output logic [1:0] memSize,
  output logic [31:0] memWdata,
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  output logic illegalSpaceEvent
);
  // ==========================================
  // State
  imd_pkg::imd_state_e state_reg, state_next;
  logic [31:0] instr_reg, instr_next;
  logic [2:0] mode_reg, mode_next;
  logic condX_reg, condX_next, condY_reg, condY_next;
  logic [3:0] idxSel_reg, idxSel_next, dregSel_reg, dregSel_next;
  logic fault_reg, fault_next, xDone_reg, xDone_next, yDone_reg, yDone_next;
  logic [1:0] rdStage_reg, rdStage_next;
  logic [31:0] readData_reg, readData_next;
  logic [31:0] idxVal_reg, idxVal_next, addrX_reg, addrX_next, addrY_reg, addrY_next;
  logic [31:0] dxVal_reg, dxVal_next, dyVal_reg, dyVal_next;
  logic [31:0] loadX_reg, loadX_next, loadY_reg, loadY_next, kVal_reg, kVal_next;
  logic execX_reg, execX_next, execY_reg, execY_next;
  logic irq_reg, irq_next;
  logic [31:0] idxRd, dxRd, dyRd;
  logic idxWe, dxWe, dyWe;
  logic [31:0] idxWd, dxWd, dyWd;
  logic [3:0] idxRa, dRa, idxWa, dWa;
  logic busy, busAcc, wrIdle;
  // ==========================================
  // Instruction decode
  logic [4:0] condCode;
  logic isStore, isProg, isPost, uncond, bcast, sizeLegal, subWord, signExt;
  logic [3:0] idxNum, dregNum;
  logic [2:0] sizeOpt;
  logic [31:0] immExt, kSel;
  logic [1:0] sizeCode;

  always_comb
  begin
    condCode = instr_reg[imd_pkg::COND_LSB +: 5];
    isProg = instr_reg[imd_pkg::G_BIT];
    isStore = instr_reg[imd_pkg::D_BIT];
    isPost = instr_reg[imd_pkg::U_BIT];
    idxNum = {isProg, instr_reg[imd_pkg::IDX_LSB +: 3]};
    dregNum = instr_reg[imd_pkg::DREG_LSB +: 4];
    immExt = {{26{instr_reg[imd_pkg::IMM_LSB + 5]}}, instr_reg[imd_pkg::IMM_LSB +: 6]};
    sizeOpt = instr_reg[imd_pkg::SIZE_LSB +: 3];
    uncond = (condCode == imd_pkg::COND_ALWAYS);
    sizeLegal = 1'b1;
    signExt = 1'b0;
    sizeCode = imd_pkg::MSZ_WORD;
    // store size vs load size-sign field
    unique case (sizeOpt)
      imd_pkg::SIZE_NW: sizeCode = imd_pkg::MSZ_WORD;
      imd_pkg::SIZE_BW: sizeCode = imd_pkg::MSZ_BYTE;
      imd_pkg::SIZE_SW: sizeCode = imd_pkg::MSZ_SHORT;
      imd_pkg::SIZE_BWSE:
      begin
        sizeCode = imd_pkg::MSZ_BYTE;
        signExt = 1'b1;
        sizeLegal = !isStore;
      end
      imd_pkg::SIZE_SWSE:
      begin
        sizeCode = imd_pkg::MSZ_SHORT;
        signExt = 1'b1;
        sizeLegal = !isStore;
      end
      default: sizeLegal = 1'b0;
    endcase
    subWord = (sizeCode != imd_pkg::MSZ_WORD);
    // broadcast read on index 1 or 9
    bcast = !isStore && ((idxNum == imd_pkg::BCAST_GEN1_IDX && mode_reg[imd_pkg::MODE_BCAST1_BIT])
      || (idxNum == imd_pkg::BCAST_GEN2_IDX && mode_reg[imd_pkg::MODE_BCAST2_BIT]));
    if (bcast)
    begin
      kSel = imd_pkg::K_BCAST;
    end
    else if (sizeCode == imd_pkg::MSZ_BYTE)
    begin
      kSel = imd_pkg::K_BW;
    end
    else if (sizeCode == imd_pkg::MSZ_SHORT)
    begin
      kSel = imd_pkg::K_SW;
    end
    else
    begin
      kSel = imd_pkg::K_NW;
    end
  end

  // ==========================================
  // Data fitting
  function automatic logic [31:0] fitLoad(input logic [31:0] raw, input logic [1:0] sz, input logic sx);
    logic [31:0] res;
    res = raw;
    if (sz == imd_pkg::MSZ_BYTE)
    begin
      res = {{24{sx & raw[7]}}, raw[7:0]};
    end
    else if (sz == imd_pkg::MSZ_SHORT)
    begin
      res = {{16{sx & raw[15]}}, raw[15:0]};
    end
    return res;
  endfunction

  function automatic logic [31:0] fitStore(input logic [31:0] val, input logic [1:0] sz);
    logic [31:0] res;
    res = val;
    if (sz == imd_pkg::MSZ_BYTE)
    begin
      res = {24'h0, val[7:0]};
    end
    else if (sz == imd_pkg::MSZ_SHORT)
    begin
      res = {16'h0, val[15:0]};
    end
    return res;
  endfunction

  // ==========================================
  // Register banks
  imd_reg_bank idxBank (.mclk(mclk), .reset(reset), .wrEn(idxWe), .wrAddr(idxWa), .wrData(idxWd),
    .rdAddr(idxRa), .rdData(idxRd));
  imd_reg_bank dxBank (.mclk(mclk), .reset(reset), .wrEn(dxWe), .wrAddr(dWa), .wrData(dxWd),
    .rdAddr(dRa), .rdData(dxRd));
  imd_reg_bank dyBank (.mclk(mclk), .reset(reset), .wrEn(dyWe), .wrAddr(dWa), .wrData(dyWd),
    .rdAddr(dRa), .rdData(dyRd));

  // ==========================================
  // Bus slave and engine next state
  always_comb
  begin
    busy = (state_reg != imd_pkg::ST_IDLE);
    busAcc = (avsRead || avsWrite) && !busy;
    wrIdle = avsWrite && !busy;
    state_next = state_reg;
    instr_next = instr_reg;
    mode_next = mode_reg;
    condX_next = condX_reg;
    condY_next = condY_reg;
    idxSel_next = idxSel_reg;
    dregSel_next = dregSel_reg;
    fault_next = fault_reg;
    xDone_next = xDone_reg;
    yDone_next = yDone_reg;
    rdStage_next = rdStage_reg;
    readData_next = readData_reg;
    idxVal_next = idxVal_reg;
    addrX_next = addrX_reg;
    addrY_next = addrY_reg;
    dxVal_next = dxVal_reg;
    dyVal_next = dyVal_reg;
    loadX_next = loadX_reg;
    loadY_next = loadY_reg;
    kVal_next = kVal_reg;
    execX_next = execX_reg;
    execY_next = execY_reg;
    irq_next = 1'b0;
    idxRa = busy ? idxNum : idxSel_reg;
    dRa = busy ? dregNum : dregSel_reg;
    idxWe = wrIdle && (avsAddress == imd_pkg::OFF_IDX_DATA);
    dxWe = wrIdle && (avsAddress == imd_pkg::OFF_DX_DATA);
    dyWe = wrIdle && (avsAddress == imd_pkg::OFF_DY_DATA);
    idxWa = idxSel_reg;
    dWa = dregSel_reg;
    idxWd = avsWritedata;
    dxWd = avsWritedata;
    dyWd = avsWritedata;
    if (avsRead && busAcc)
    begin
      rdStage_next = (rdStage_reg == 2'h2) ? 2'h0 : rdStage_reg + 2'h1;
      unique case (avsAddress)
        imd_pkg::OFF_INSTR: readData_next = instr_reg;
        imd_pkg::OFF_CTRL: readData_next = {29'h0, condY_reg, condX_reg, 1'b0};
        imd_pkg::OFF_MODE: readData_next = {29'h0, mode_reg};
        imd_pkg::OFF_STATUS: readData_next = {28'h0, yDone_reg, xDone_reg, fault_reg, busy};
        imd_pkg::OFF_IDX_SEL: readData_next = {28'h0, idxSel_reg};
        imd_pkg::OFF_IDX_DATA: readData_next = idxRd;
        imd_pkg::OFF_DREG_SEL: readData_next = {28'h0, dregSel_reg};
        imd_pkg::OFF_DX_DATA: readData_next = dxRd;
        imd_pkg::OFF_DY_DATA: readData_next = dyRd;
        default: readData_next = 32'h0;
      endcase
    end
    if (wrIdle)
    begin
      unique case (avsAddress)
        imd_pkg::OFF_INSTR: instr_next = avsWritedata;
        imd_pkg::OFF_MODE: mode_next = avsWritedata[2:0];
        imd_pkg::OFF_IDX_SEL: idxSel_next = avsWritedata[3:0];
        imd_pkg::OFF_DREG_SEL: dregSel_next = avsWritedata[3:0];
        imd_pkg::OFF_CTRL:
        begin
          condX_next = avsWritedata[imd_pkg::CTRL_CONDX_BIT];
          condY_next = avsWritedata[imd_pkg::CTRL_CONDY_BIT];
          if (avsWritedata[imd_pkg::CTRL_GO_BIT])
          begin
            state_next = imd_pkg::ST_FETCH;
            fault_next = 1'b0;
            xDone_next = 1'b0;
            yDone_next = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end
    unique case (state_reg)
      imd_pkg::ST_IDLE:
      begin
      end
      imd_pkg::ST_FETCH: state_next = imd_pkg::ST_CALC;
      imd_pkg::ST_CALC:
      begin
        idxVal_next = idxRd;
        dxVal_next = dxRd;
        dyVal_next = dyRd;
        kVal_next = kSel;
        // premodify adds offset, postmodify uses index
        // secondary base is index plus k
        addrX_next = isPost ? idxRd : idxRd + immExt;
        addrY_next = isPost ? idxRd + kSel : idxRd + kSel + immExt;
        execX_next = uncond || condX_reg;
        execY_next = mode_reg[imd_pkg::MODE_SIMD_BIT] && (uncond || condY_reg);
        if (!sizeLegal || (subWord && !idxRd[imd_pkg::BYTE_SPACE_BIT]))
        begin
          fault_next = 1'b1;
          irq_next = 1'b1;
          state_next = imd_pkg::ST_IDLE;
        end
        else
        begin
          state_next = imd_pkg::ST_MEMX;
        end
      end
      imd_pkg::ST_MEMX:
      begin
        if (!execX_reg)
        begin
          state_next = imd_pkg::ST_MEMY;
        end
        else if (memAck)
        begin
          loadX_next = fitLoad(memRdata, sizeCode, signExt);
          state_next = imd_pkg::ST_MEMY;
        end
      end
      imd_pkg::ST_MEMY:
      begin
        if (!execY_reg)
        begin
          state_next = imd_pkg::ST_WBACK;
        end
        else if (memAck)
        begin
          loadY_next = fitLoad(memRdata, sizeCode, signExt);
          state_next = imd_pkg::ST_WBACK;
        end
      end
      imd_pkg::ST_WBACK:
      begin
        dxWe = !isStore && execX_reg;
        dyWe = !isStore && execY_reg;
        dWa = dregNum;
        dxWd = loadX_reg;
        dyWd = loadY_reg;
        idxWe = isPost && (execX_reg || execY_reg);
        idxWa = idxNum;
        idxWd = idxVal_reg + immExt;
        xDone_next = execX_reg;
        yDone_next = execY_reg;
        state_next = imd_pkg::ST_IDLE;
      end
      default: state_next = imd_pkg::ST_IDLE;
    endcase
  end

  // ==========================================
  // Registers
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= imd_pkg::ST_IDLE;
      instr_reg <= imd_pkg::INSTR_RESET;
      mode_reg <= imd_pkg::MODE_RESET;
      condX_reg <= 1'b0;
      condY_reg <= 1'b0;
      idxSel_reg <= 4'h0;
      dregSel_reg <= 4'h0;
      fault_reg <= 1'b0;
      xDone_reg <= 1'b0;
      yDone_reg <= 1'b0;
      rdStage_reg <= 2'h0;
      readData_reg <= 32'h0;
      idxVal_reg <= 32'h0;
      addrX_reg <= 32'h0;
      addrY_reg <= 32'h0;
      dxVal_reg <= 32'h0;
      dyVal_reg <= 32'h0;
      loadX_reg <= 32'h0;
      loadY_reg <= 32'h0;
      kVal_reg <= 32'h0;
      execX_reg <= 1'b0;
      execY_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      instr_reg <= instr_next;
      mode_reg <= mode_next;
      condX_reg <= condX_next;
      condY_reg <= condY_next;
      idxSel_reg <= idxSel_next;
      dregSel_reg <= dregSel_next;
      fault_reg <= fault_next;
      xDone_reg <= xDone_next;
      yDone_reg <= yDone_next;
      rdStage_reg <= rdStage_next;
      readData_reg <= readData_next;
      idxVal_reg <= idxVal_next;
      addrX_reg <= addrX_next;
      addrY_reg <= addrY_next;
      dxVal_reg <= dxVal_next;
      dyVal_reg <= dyVal_next;
      loadX_reg <= loadX_next;
      loadY_reg <= loadY_next;
      kVal_reg <= kVal_next;
      execX_reg <= execX_next;
      execY_reg <= execY_next;
      irq_reg <= irq_next;
    end
  end

  // ==========================================
  // Outputs
  assign avsWaitrequest = busy || (avsRead && rdStage_reg != 2'h2);
  assign avsReaddata = readData_reg;
  assign memReq = (state_reg == imd_pkg::ST_MEMX && execX_reg) || (state_reg == imd_pkg::ST_MEMY && execY_reg);
  assign memWrite = isStore;
  assign memProgSpace = isProg;
  assign memSize = sizeCode;
  assign memAddr = (state_reg == imd_pkg::ST_MEMY) ? addrY_reg : addrX_reg;
  assign memWdata = fitStore((state_reg == imd_pkg::ST_MEMY) ? dyVal_reg : dxVal_reg, sizeCode);
  assign illegalSpaceEvent = irq_reg;

  // ==========================================
  // Checks
  // unconditional code runs primary
  AST_UNCOND_RUNS: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == imd_pkg::ST_CALC && uncond && state_next == imd_pkg::ST_MEMX) |=> execX_reg)
    else $error("Unconditional move not executed");
  AST_PREMOD_ADDR: assert property (@(posedge mclk) disable iff (reset)
    (memReq && state_reg == imd_pkg::ST_MEMX && !isPost) |-> memAddr == idxVal_reg + immExt)
    else $error("Premodified address wrong");
  AST_POST_WB: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == imd_pkg::ST_WBACK && isPost && execX_reg) |-> (idxWe && idxWd == idxVal_reg + immExt))
    else $error("Postmodify write back missing");
  // no index update without postmodify and true element
  AST_NO_WB: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == imd_pkg::ST_WBACK && (!isPost || (!execX_reg && !execY_reg))) |-> !idxWe)
    else $error("Unexpected index update");
  AST_Y_OFFSET: assert property (@(posedge mclk) disable iff (reset)
    (memReq && state_reg == imd_pkg::ST_MEMY) |-> memAddr == addrX_reg + kVal_reg)
    else $error("Secondary address offset wrong");
  AST_BCAST_SAME: assert property (@(posedge mclk) disable iff (reset)
    (memReq && state_reg == imd_pkg::ST_MEMY && bcast) |-> memAddr == addrX_reg)
    else $error("Broadcast read address differs");
  AST_QUIET: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == imd_pkg::ST_MEMX && !execX_reg) |-> !memReq ##1 state_reg == imd_pkg::ST_MEMY)
    else $error("Access despite false condition");
  AST_FAULT: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == imd_pkg::ST_CALC && subWord && !idxRd[imd_pkg::BYTE_SPACE_BIT])
    |=> (illegalSpaceEvent && fault_reg && state_reg == imd_pkg::ST_IDLE && !memReq))
    else $error("Byte space fault not raised");
  AST_STORE_MASK: assert property (@(posedge mclk) disable iff (reset)
    (memReq && memWrite && memSize == imd_pkg::MSZ_BYTE) |-> memWdata[31:8] == 24'h0)
    else $error("Byte store upper bits not clear");
  AST_SISD_NO_Y: assert property (@(posedge mclk) disable iff (reset)
    (state_reg == imd_pkg::ST_CALC && !mode_reg[imd_pkg::MODE_SIMD_BIT]) |=> !execY_reg)
    else $error("Secondary ran outside SIMD");
endmodule
`default_nettype wire

// *** hdl/imd_pkg.sv ***
// ==========================================
// Shared constants for the indexed move decoder
`default_nettype none
package imd_pkg;
  localparam int DATA_W = 32;
  // ==========================================
  // Register byte offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_IDX_SEL = 8'h10;
  localparam logic [7:0] OFF_IDX_DATA = 8'h14;
  localparam logic [7:0] OFF_DREG_SEL = 8'h18;
  localparam logic [7:0] OFF_DX_DATA = 8'h1c;
  localparam logic [7:0] OFF_DY_DATA = 8'h20;
  // ==========================================
  // Instruction word fields
  localparam int COND_LSB = 0;
  localparam int U_BIT = 5;
  localparam int D_BIT = 6;
  localparam int G_BIT = 7;
  localparam int IDX_LSB = 8;
  localparam int DREG_LSB = 12;
  localparam int IMM_LSB = 16;
  localparam int SIZE_LSB = 22;
  localparam logic [31:0] INSTR_RESET = 32'h01c0001f;
  localparam logic [4:0] COND_ALWAYS = 5'h1f;
  // ==========================================
  // Size option codes
  localparam logic [2:0] SIZE_NW = 3'h7;
  localparam logic [2:0] SIZE_BW = 3'h0;
  localparam logic [2:0] SIZE_SW = 3'h4;
  localparam logic [2:0] SIZE_BWSE = 3'h2;
  localparam logic [2:0] SIZE_SWSE = 3'h6;
  // ==========================================
  // Secondary element offsets
  localparam logic [31:0] K_NW = 32'h1;
  localparam logic [31:0] K_SW = 32'h2;
  localparam logic [31:0] K_BW = 32'h4;
  localparam logic [31:0] K_BCAST = 32'h0;
  localparam logic [3:0] BCAST_GEN1_IDX = 4'h1;
  localparam logic [3:0] BCAST_GEN2_IDX = 4'h9;
  // ==========================================
  // Control, mode and status bits
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_CONDX_BIT = 1;
  localparam int CTRL_CONDY_BIT = 2;
  localparam int MODE_SIMD_BIT = 0;
  localparam int MODE_BCAST1_BIT = 1;
  localparam int MODE_BCAST2_BIT = 2;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_FAULT_BIT = 1;
  localparam int ST_XDONE_BIT = 2;
  localparam int ST_YDONE_BIT = 3;
  localparam int BYTE_SPACE_BIT = 31;
  // ==========================================
  // Memory access size codes and engine state encoding
  localparam logic [1:0] MSZ_BYTE = 2'h0;
  localparam logic [1:0] MSZ_SHORT = 2'h1;
  localparam logic [1:0] MSZ_WORD = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FETCH = 3'h1,
    ST_CALC = 3'h3,
    ST_MEMX = 3'h2,
    ST_MEMY = 3'h6,
    ST_WBACK = 3'h7
  } imd_state_e;
endpackage
`default_nettype wire

// *** hdl/imd_reg_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Sixteen word register bank, registered read
module imd_reg_bank (
  input wire logic mclk,
  input wire logic reset,
  input wire logic wrEn,
  input wire logic [3:0] wrAddr,
  input wire logic [31:0] wrData,
  input wire logic [3:0] rdAddr,
  output logic [31:0] rdData
);
  logic [31:0] store [16];
  logic [31:0] rdData_reg;
  logic [31:0] rdData_next;

  always_comb
  begin
    rdData_next = store[rdAddr];
  end

  always_ff @(posedge mclk)
  begin
    if (wrEn)
    begin
      store[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      rdData_reg <= 32'h0;
    end
    else
    begin
      rdData_reg <= rdData_next;
    end
  end

  assign rdData = rdData_reg;
endmodule
`default_nettype wire

// *** sim/imd_decode_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module imd_decode_top_tb;
  logic mclk, reset, avsRead, avsWrite, avsWaitrequest, memReq, memWrite, memProgSpace, memAck, illegalSpaceEvent;
  logic [7:0] avsAddress;
  logic [31:0] avsWritedata, avsReaddata, memAddr, memWdata, memRdata, rd, a;
  logic [1:0] memSize;
  logic [3:0] lat;
  logic [31:0] qA[$], qD[$];
  logic [3:0] qM[$];
  logic [2:0] szt[4] = '{3'h0, 3'h4, 3'h2, 3'h6};
  logic [31:0] kt[4] = '{32'h4, 32'h2, 32'h4, 32'h2};
  int n_fail, checks, cyc, nEvt, n0;
  imd_decode_top DUT (.mclk(mclk), .reset(reset), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .memReq(memReq), .memWrite(memWrite), .memProgSpace(memProgSpace),
    .memAddr(memAddr), .memSize(memSize), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata),
    .illegalSpaceEvent(illegalSpaceEvent));
  imd_mem_model MEM (.mclk(mclk), .reset(reset), .memReq(memReq), .memAddr(memAddr), .lat(lat),
    .memAck(memAck), .memRdata(memRdata));
  // ==========================================
  // Clock, access log, timeout
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (memReq === 1'b1 && memAck === 1'b1)
    begin
      qA.push_back(memAddr);
      qD.push_back(memWdata);
      qM.push_back({memWrite, memProgSpace, memSize});
    end
    if (illegalSpaceEvent === 1'b1)
      nEvt++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  // ==========================================
  // Helpers
  function automatic logic [31:0] mk(logic [4:0] c, logic [2:0] gdu, logic [2:0] i, logic [3:0] r,
    logic [5:0] m, logic [2:0] s);
    return {7'h0, s, m, r, 1'b0, i, gdu, c};
  endfunction
  function automatic logic [31:0] pat(logic [31:0] x);
    return 32'hc3a59080 + x;
  endfunction
  function automatic logic [31:0] ext(logic [2:0] s, logic [31:0] v);
    case (s)
      3'h0: return {24'h0, v[7:0]};
      3'h4: return {16'h0, v[15:0]};
      3'h2: return {{24{v[7]}}, v[7:0]};
      3'h6: return {{16{v[15]}}, v[15:0]};
      default: return v;
    endcase
  endfunction
  task end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task acc(input logic w, input logic [7:0] ad, input logic [31:0] d);
    avsAddress <= ad;
    avsWritedata <= d;
    avsWrite <= w;
    avsRead <= ~w;
    @(posedge mclk);
    while (avsWaitrequest !== 1'b0)
      @(posedge mclk);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge mclk);
  endtask
  task setIdx(input logic [3:0] n, input logic [31:0] v);
    acc(1'b1, imd_pkg::OFF_IDX_SEL, {28'h0, n});
    acc(1'b1, imd_pkg::OFF_IDX_DATA, v);
  endtask
  task chkIdx(input logic [3:0] n, input logic [31:0] e);
    acc(1'b1, imd_pkg::OFF_IDX_SEL, {28'h0, n});
    acc(1'b0, imd_pkg::OFF_IDX_DATA, 32'h0);
    chk("index", e, rd);
  endtask
  task setD(input logic [3:0] n, input logic [31:0] x, input logic [31:0] y);
    acc(1'b1, imd_pkg::OFF_DREG_SEL, {28'h0, n});
    acc(1'b1, imd_pkg::OFF_DX_DATA, x);
    acc(1'b1, imd_pkg::OFF_DY_DATA, y);
  endtask
  task chkD(input logic [3:0] n, input logic [31:0] ex, input logic [31:0] ey);
    acc(1'b1, imd_pkg::OFF_DREG_SEL, {28'h0, n});
    acc(1'b0, imd_pkg::OFF_DX_DATA, 32'h0);
    chk("primary data", ex, rd);
    acc(1'b0, imd_pkg::OFF_DY_DATA, 32'h0);
    chk("secondary data", ey, rd);
  endtask
  task run(input logic [31:0] ins, input logic [2:0] mode, input logic [1:0] cnd, input int n);
    acc(1'b1, imd_pkg::OFF_MODE, {29'h0, mode});
    acc(1'b1, imd_pkg::OFF_INSTR, ins);
    qA.delete();
    qD.delete();
    qM.delete();
    acc(1'b1, imd_pkg::OFF_CTRL, {29'h0, cnd, 1'b1});
    acc(1'b0, imd_pkg::OFF_STATUS, 32'h0);
    chk("accesses", n, qA.size());
  endtask
  task chkAcc(input int i, input logic [31:0] ad, input logic [3:0] m);
    chk("address", ad, qA[i]);
    chk("kind", {28'h0, m}, {28'h0, qM[i]});
  endtask
  // ==========================================
  // Tests
  initial
  begin
    reset = 1'b1;
    {avsRead, avsWrite, avsAddress, avsWritedata, lat} = '0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    acc(1'b0, imd_pkg::OFF_INSTR, 32'h0);
    chk("instr reset", imd_pkg::INSTR_RESET, rd);
    acc(1'b0, imd_pkg::OFF_MODE, 32'h0);
    chk("mode reset", 32'h0, rd);
    setIdx(4'h2, 32'h100);
    setD(4'h3, 32'h0, 32'h0);
    run(mk(5'h1f, 3'h0, 3'h2, 4'h3, 6'h3d, 3'h7), 3'h0, 2'h0, 1);
    chkAcc(0, 32'hfd, 4'h2);
    chkD(4'h3, pat(32'hfd), 32'h0);
    chkIdx(4'h2, 32'h100);
    lat <= 4'h3;
    setIdx(4'h9, 32'h40);
    setD(4'h4, 32'h12345678, 32'h0);
    run(mk(5'h1f, 3'h7, 3'h1, 4'h4, 6'h05, 3'h7), 3'h0, 2'h0, 1);
    chkAcc(0, 32'h40, 4'he);
    chk("store data", 32'h12345678, qD[0]);
    chkIdx(4'h9, 32'h45);
    lat <= 4'h0;
    run(mk(5'h04, 3'h1, 3'h2, 4'h3, 6'h01, 3'h7), 3'h0, 2'h0, 0);
    chkIdx(4'h2, 32'h100);
    chkD(4'h3, pat(32'hfd), 32'h0);
    run(mk(5'h04, 3'h1, 3'h2, 4'h5, 6'h02, 3'h7), 3'h1, 2'h3, 2);
    chkAcc(1, 32'h101, 4'h2);
    chkD(4'h5, pat(32'h100), pat(32'h101));
    chkIdx(4'h2, 32'h102);
    setD(4'h6, 32'haaaa0001, 32'hbbbb0002);
    run(mk(5'h04, 3'h2, 3'h2, 4'h6, 6'h01, 3'h7), 3'h1, 2'h2, 1);
    chkAcc(0, 32'h104, 4'ha);
    chk("store data", 32'hbbbb0002, qD[0]);
    chk("status", 32'h8, rd);
    setIdx(4'h0, 32'h80000010);
    for (int i = 0; i < 4; i++)
    begin
      a = 32'h80000010 + kt[i];
      run(mk(5'h1f, 3'h0, 3'h0, 4'h7, 6'h00, szt[i]), 3'h1, 2'h0, 2);
      chkAcc(1, a, {3'h0, kt[i] == 32'h2});
      chkD(4'h7, ext(szt[i], pat(32'h80000010)), ext(szt[i], pat(a)));
    end
    setD(4'h8, 32'hdeadbeef, 32'h0);
    run(mk(5'h1f, 3'h2, 3'h0, 4'h8, 6'h00, 3'h4), 3'h0, 2'h0, 1);
    chk("store data", 32'h0000beef, qD[0]);
    n0 = nEvt;
    run(mk(5'h1f, 3'h0, 3'h2, 4'h3, 6'h00, 3'h0), 3'h0, 2'h0, 0);
    chk("fault", 32'h1, {31'h0, rd[1]});
    run(mk(5'h1f, 3'h2, 3'h0, 4'h8, 6'h00, 3'h2), 3'h0, 2'h0, 0);
    chk("events", n0 + 2, nEvt);
    setIdx(4'h1, 32'h200);
    run(mk(5'h1f, 3'h0, 3'h1, 4'h9, 6'h00, 3'h7), 3'h3, 2'h0, 2);
    chkAcc(1, 32'h200, 4'h2);
    chkD(4'h9, pat(32'h200), pat(32'h200));
    setIdx(4'h9, 32'h300);
    run(mk(5'h1f, 3'h4, 3'h1, 4'h9, 6'h00, 3'h7), 3'h5, 2'h0, 2);
    chkAcc(1, 32'h300, 4'h6);
    end_of_test();
  end
endmodule
`default_nettype wire

// *** sim/imd_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Core memory: acknowledges after lat idle cycles
module imd_mem_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic memReq,
  input wire logic [31:0] memAddr,
  input wire logic [3:0] lat,
  output logic memAck,
  output var logic [31:0] memRdata
);
  logic [3:0] waitCnt;
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      memAck <= 1'b0;
      waitCnt <= 4'h0;
    end
    else if (memReq && !memAck && waitCnt >= lat)
    begin
      memAck <= 1'b1;
      waitCnt <= 4'h0;
    end
    else
    begin
      memAck <= 1'b0;
      if (memReq && !memAck)
        waitCnt <= waitCnt + 4'h1;
    end
  end
  // Data only valid with the acknowledge
  always_comb
    memRdata = memAck ? 32'hc3a59080 + memAddr : ~(32'hc3a59080 + memAddr);
endmodule
`default_nettype wire
